// ---- logic/csm_spi_master.sv ----
/*
  Configurable serial master with an APB register slave, a four-word
  transmit FIFO, a one-word receive holding register and a serial engine.
  Assumes a 50 MHz sys_clk, asynchronous active-high reset, one attached
  slave, and a clock enable that freezes all state while low.
*/
// Design decisions made here: register access over APB and the register addresses.
// Overview of operation
// R1: A read operation clocks in the requested number of words and returns each masked to the word width.
// R2: An exchange shifts out each supplied word while capturing one word from the input line.
// R3: After an exchange the number of captured words equals the number of words shifted out.
// R4: A write operation shifts out supplied words and reports how many were sent, possibly fewer.
// R5: Software supplies only words that fit within the configured word width.
// R6: The word width sets bits per word and the word boundaries, and resets to 8 bits.
// R7: The two-bit clock mode holds polarity in its upper bit and phase in its lower bit, written together.
// R8: With phase clear data is sampled on the activating edge, with phase set on the deactivating edge.
// R9: With polarity clear the clock idles low and pulses high, with polarity set the reverse.
// R10: Bit order selects LSB-first shifting in both directions and defaults to MSB first.
// R11: The serial clock runs at a rate set in hertz, and a rate that cannot be met is flagged as an error.
// R12: With select polarity clear chip select is active low, with it set active high.
// R13: Chip select asserts before the first clock edge, holds to the last word, then returns to idle.
module csm_spi_master
  import csm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             spi_sclk,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  output logic             spi_cs
);

  // Configuration and status registers
  logic        cpha_reg;
  logic        cpol_reg;
  logic        lsb_reg;
  logic        selh_reg;
  logic [5:0]  wid_reg;
  logic [31:0] rate_reg;
  logic        rate_err_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  // Engine registers
  csm_state_e  state_reg;
  csm_state_e  state_next;
  csm_op_e     op_reg;
  logic [15:0] left_reg;
  logic [15:0] left_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [5:0]  edge_reg;
  logic [5:0]  edge_next;
  logic [31:0] tx_sh_reg;
  logic [31:0] tx_sh_next;
  logic [31:0] rx_sh_reg;
  logic [31:0] rx_sh_next;
  logic [31:0] rx_hold_reg;
  logic        rx_set;
  logic        rx_valid_reg;
  logic        sclk_reg;
  logic        sclk_next;
  logic        mosi_reg;
  logic        mosi_next;
  logic        cs_reg;
  logic        cs_next;
  logic [31:0] acc_reg;
  logic        tx_pop;
  logic        miso_s1_reg;
  logic        miso_s2_reg;
  logic        miso_s3_reg;
  logic        miso_reg;

  // FIFO wires
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [31:0] fifo_out_data;

  // APB decode
  wire acc_phase  = psel & penable & ~pready_reg;
  wire xfer_done  = psel & penable & pready_reg;
  wire wr_done    = xfer_done & pwrite;
  wire rd_done    = xfer_done & ~pwrite;
  wire hit_ctrl   = (paddr == `CSM_OFS_CTRL);
  wire hit_rate   = (paddr == `CSM_OFS_RATE);
  wire hit_cmd    = (paddr == `CSM_OFS_CMD);
  wire hit_txd    = (paddr == `CSM_OFS_TXDATA);
  wire hit_rxd    = (paddr == `CSM_OFS_RXDATA);
  wire hit_stat   = (paddr == `CSM_OFS_STATUS);
  wire mapped     = hit_ctrl | hit_rate | hit_cmd | hit_txd | hit_rxd | hit_stat;
  // A full FIFO holds pready low, so the writer stalls rather than loses data
  wire tx_stall   = hit_txd & pwrite & ~fifo_in_ready;
  wire idle       = (state_reg == CSM_IDLE);
  wire ctrl_wr    = wr_done & hit_ctrl & idle;
  wire [5:0] wid_wr = pwdata[`CSM_CTRL_WID_HI:`CSM_CTRL_WID_LO];
  wire wid_ok     = (wid_wr != 6'h00) && (wid_wr <= `CSM_WID_MAX);
  wire rate_wr    = wr_done & hit_rate;
  wire rate_ok    = (pwdata != 32'h00000000) && (pwdata <= `CSM_RATE_MAX);
  wire start      = wr_done & hit_cmd & idle;
  wire rx_pop     = rd_done & hit_rxd;
  wire err_clr    = wr_done & hit_stat & pwdata[`CSM_ST_RATEERR];

  wire [31:0] ctrl_val = {18'h00000, wid_reg, 4'h0, selh_reg, lsb_reg, cpol_reg, cpha_reg};
  wire [31:0] stat_val = {cnt_reg, 11'h000, rate_err_reg, ~fifo_out_valid,
                          ~fifo_in_ready, rx_valid_reg, ~idle};
  wire [31:0] rd_mux   = hit_ctrl ? ctrl_val :
                         hit_rate ? rate_reg :
                         hit_rxd  ? rx_hold_reg :
                         hit_stat ? stat_val : 32'h00000000;

  // Word geometry
  wire [5:0]  sh_amt   = 6'h20 - wid_reg;
  wire [31:0] wmask    = 32'hffffffff >> sh_amt;
  wire [5:0]  last_edge = {wid_reg[4:0], 1'b0} - 6'h01;
  wire [31:0] tx_word  = (op_reg == CSM_OP_READ) ? 32'h00000000 : (fifo_out_data & wmask);
  // Left-align for MSB first so bit 31 always leads
  wire [31:0] tx_align = lsb_reg ? tx_word : (tx_word << sh_amt); // R10
  wire        tx_first = lsb_reg ? tx_align[0] : tx_align[31];
  wire        needs_tx = (op_reg != CSM_OP_READ);
  wire        needs_rx = (op_reg != CSM_OP_WRITE);

  // Rate generator: phase accumulator stepping twice the rate per cycle
  wire [31:0] acc_sum  = acc_reg + {rate_reg[30:0], 1'b0}; // R11
  wire        tick     = (acc_sum >= `CSM_SYS_HZ);
  wire        run      = (state_reg == CSM_LEAD) | (state_reg == CSM_SHIFT) |
                         (state_reg == CSM_TAIL);
  wire [31:0] acc_next = !run ? 32'h00000000 : (tick ? acc_sum - `CSM_SYS_HZ : acc_sum);

  // Edge classification within a word
  wire leading   = ~edge_reg[0];
  wire sample    = leading ^ cpha_reg; // R8
  wire out_evt   = cpha_reg ? leading : (~leading && (edge_reg != last_edge));
  wire shift_tx  = cpha_reg ? (edge_reg != 6'h00) : 1'b1;
  wire [31:0] tx_shifted = lsb_reg ? {1'b0, tx_sh_reg[31:1]} : {tx_sh_reg[30:0], 1'b0};
  wire [31:0] rx_shifted = lsb_reg ? {miso_reg, rx_sh_reg[31:1]} : {rx_sh_reg[30:0], miso_reg};
  // With phase clear the last edge of a word is not a sampling edge: take no extra shift
  wire [31:0] rx_fin     = sample ? rx_shifted : rx_sh_reg;
  wire [31:0] rx_word    = lsb_reg ? (rx_fin >> sh_amt) : (rx_fin & wmask); // R1

  always_comb begin
    state_next = state_reg;
    left_next  = left_reg;
    cnt_next   = cnt_reg;
    edge_next  = edge_reg;
    tx_sh_next = tx_sh_reg;
    rx_sh_next = rx_sh_reg;
    sclk_next  = sclk_reg;
    mosi_next  = mosi_reg;
    cs_next    = cs_reg;
    rx_set     = 1'b0;
    tx_pop     = 1'b0;
    case (state_reg)
      CSM_IDLE: begin
        sclk_next = cpol_reg; // R9
        cs_next   = ~selh_reg; // R12
        if (start) begin
          left_next  = pwdata[`CSM_CMD_CNT_HI:`CSM_CMD_CNT_LO];
          cnt_next   = 16'h0000;
          cs_next    = selh_reg; // R13
          state_next = CSM_LEAD;
        end
      end
      CSM_LEAD: begin
        if (tick) state_next = CSM_LOAD;
      end
      CSM_LOAD: begin
        // A write or exchange ends early when the FIFO runs dry
        if (left_reg == 16'h0000 || (needs_tx && !fifo_out_valid)) begin // R4
          state_next = CSM_TAIL;
        end else if (!(needs_rx && rx_valid_reg)) begin
          tx_pop     = needs_tx;
          tx_sh_next = tx_align;
          mosi_next  = tx_first;
          edge_next  = 6'h00;
          state_next = CSM_SHIFT;
        end
      end
      CSM_SHIFT: begin
        if (tick) begin
          sclk_next = ~sclk_reg;
          edge_next = edge_reg + 6'h01;
          if (sample) rx_sh_next = rx_shifted; // R2
          if (out_evt) begin
            if (shift_tx) tx_sh_next = tx_shifted;
            mosi_next = lsb_reg ? (shift_tx ? tx_sh_reg[1] : tx_sh_reg[0])
                                : (shift_tx ? tx_sh_reg[30] : tx_sh_reg[31]);
          end
          if (edge_reg == last_edge) begin // R6
            cnt_next   = cnt_reg + 16'h0001; // R3
            left_next  = left_reg - 16'h0001;
            rx_set     = needs_rx;
            state_next = CSM_LOAD;
          end
        end
      end
      CSM_TAIL: begin
        if (tick) begin
          cs_next    = ~selh_reg; // R13
          sclk_next  = cpol_reg;
          state_next = CSM_IDLE;
        end
      end
      default: begin
        state_next = CSM_IDLE;
      end
    endcase
  end

  csm_fifo #(
    .WIDTH (`CSM_FIFO_W),
    .DEPTH (`CSM_FIFO_DEPTH)
  ) u_txfifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_valid  (wr_done & hit_txd),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata),
    .out_valid (fifo_out_valid),
    .out_ready (tx_pop),
    .out_data  (fifo_out_data)
  );

  // APB slave and configuration
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else if (clk_en) begin
      pready_reg  <= acc_phase & ~tx_stall;
      pslverr_reg <= acc_phase & ~tx_stall & ~mapped;
      if (acc_phase && !pwrite) prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpha_reg     <= 1'b0;
      cpol_reg     <= 1'b0;
      lsb_reg      <= 1'b0;
      selh_reg     <= 1'b0;
      wid_reg      <= `CSM_WID_RST;
      rate_reg     <= `CSM_RATE_RST;
      rate_err_reg <= 1'b0;
      op_reg       <= CSM_OP_XCHG;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        {cpol_reg, cpha_reg} <= pwdata[`CSM_CTRL_CPOL:`CSM_CTRL_CPHA]; // R7
        lsb_reg  <= pwdata[`CSM_CTRL_LSB];
        selh_reg <= pwdata[`CSM_CTRL_SELH];
        if (wid_ok) wid_reg <= wid_wr;
      end
      if (rate_wr && rate_ok) rate_reg <= pwdata;
      if (rate_wr && !rate_ok) rate_err_reg <= 1'b1; // R11
      else if (err_clr) rate_err_reg <= 1'b0;
      if (start) op_reg <= csm_op_e'(pwdata[`CSM_CMD_OP_HI:`CSM_CMD_OP_LO]);
    end
  end

  // Input pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
      miso_s3_reg <= 1'b0;
      miso_reg    <= 1'b0;
    end else if (clk_en) begin
      miso_s1_reg <= spi_miso;
      miso_s2_reg <= miso_s1_reg;
      miso_s3_reg <= miso_s2_reg;
      if (miso_s2_reg == miso_s3_reg) miso_reg <= miso_s3_reg;
    end
  end

  // Serial engine
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= CSM_IDLE;
      left_reg  <= 16'h0000;
      cnt_reg   <= 16'h0000;
      edge_reg  <= 6'h00;
      tx_sh_reg <= 32'h00000000;
      rx_sh_reg <= 32'h00000000;
      sclk_reg  <= 1'b0;
      mosi_reg  <= 1'b0;
      cs_reg    <= 1'b1;
      acc_reg   <= 32'h00000000;
    end else if (clk_en) begin
      state_reg <= state_next;
      left_reg  <= left_next;
      cnt_reg   <= cnt_next;
      edge_reg  <= edge_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      sclk_reg  <= sclk_next;
      mosi_reg  <= mosi_next;
      cs_reg    <= cs_next;
      acc_reg   <= acc_next;
    end
  end

  // Receive holding word; a new word wins over a simultaneous read
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_hold_reg  <= 32'h00000000;
      rx_valid_reg <= 1'b0;
    end else if (clk_en) begin
      if (rx_set) rx_hold_reg <= rx_word;
      if (rx_set) rx_valid_reg <= 1'b1;
      else if (rx_pop) rx_valid_reg <= 1'b0;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign spi_sclk = sclk_reg;
  assign spi_mosi = mosi_reg;
  assign spi_cs   = cs_reg;
endmodule

// ---- logic/csm_params.svh ----
/*
  Constants of the configurable serial master: register offsets, field
  positions, reset values and timing figures.
  Assumes inclusion by bare name from the package; the main module uses the macros without including it.
*/
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH

// Register byte offsets on the APB
`define CSM_OFS_CTRL     8'h00
`define CSM_OFS_RATE     8'h04
`define CSM_OFS_CMD      8'h08
`define CSM_OFS_TXDATA   8'h0c
`define CSM_OFS_RXDATA   8'h10
`define CSM_OFS_STATUS   8'h14

// Control register fields
`define CSM_CTRL_CPHA    0
`define CSM_CTRL_CPOL    1
`define CSM_CTRL_LSB     2
`define CSM_CTRL_SELH    3
`define CSM_CTRL_WID_LO  8
`define CSM_CTRL_WID_HI  13

// Command register fields
`define CSM_CMD_OP_LO    0
`define CSM_CMD_OP_HI    1
`define CSM_CMD_CNT_LO   8
`define CSM_CMD_CNT_HI   23

// Status register fields
`define CSM_ST_BUSY      0
`define CSM_ST_RXV       1
`define CSM_ST_TXFULL    2
`define CSM_ST_TXEMPTY   3
`define CSM_ST_RATEERR   4
`define CSM_ST_CNT_LO    16
`define CSM_ST_CNT_HI    31

// Reset values and limits
`define CSM_WID_RST      6'h08
`define CSM_WID_MAX      6'h20
`define CSM_RATE_RST     32'h0007a120
`define CSM_SYS_HZ       32'h02faf080
`define CSM_RATE_MAX     32'h00bebc20

// Transmit buffer shape
`define CSM_FIFO_W       32
`define CSM_FIFO_DEPTH   4

`endif

// ---- logic/csm_pkg.sv ----
/*
  Types shared by the serial master: engine states and operation codes.
  Assumes csm_params.svh is on the include path.
*/
package csm_pkg;
  `include "csm_params.svh"

  typedef enum logic [2:0] {
    CSM_IDLE  = 3'b000,
    CSM_LEAD  = 3'b001,
    CSM_LOAD  = 3'b010,
    CSM_SHIFT = 3'b011,
    CSM_TAIL  = 3'b100
  } csm_state_e;

  typedef enum logic [1:0] {
    CSM_OP_XCHG  = 2'b00,
    CSM_OP_READ  = 2'b01,
    CSM_OP_WRITE = 2'b10,
    CSM_OP_RSVD  = 2'b11
  } csm_op_e;
endpackage

// ---- logic/csm_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock, asynchronous active-high reset, and a clock enable
  that freezes all state while low. DEPTH must be a power of two.
*/
module csm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      level_reg;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (level_reg != DEPTH[AW:0]);
  assign out_valid = (level_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else if (clk_en) begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop) level_reg <= level_reg + 1'b1;
      else if (pop && !push) level_reg <= level_reg - 1'b1;
    end
  end
endmodule

// ---- tb/csm_spi_master_chk.sv ----
/*
  Checker for the serial master, bound to its top module.
  Assumes one clock domain and a bench that writes CTRL only while idle.
*/
module csm_spi_master_chk (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        spi_sclk,
  input wire logic        spi_mosi,
  input wire logic        spi_miso,
  input wire logic        spi_cs
);
  logic       cpol_q;
  logic       cpha_q;
  logic       selh_q;
  logic [1:0] age_q;
  wire        act    = (spi_cs == selh_q);
  wire        quiet  = (age_q == 2'h3);
  wire        ctl_wr = psel && penable && pready && pwrite && (paddr == 8'h00) && !act;

  // Shadow of the mode bits; age masks the cycles in which outputs catch up
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpol_q <= 1'b0;
      cpha_q <= 1'b0;
      selh_q <= 1'b0;
      age_q  <= 2'h3;
    end else if (ctl_wr) begin
      cpha_q <= pwdata[0];
      cpol_q <= pwdata[1];
      selh_q <= pwdata[3];
      age_q  <= 2'h0;
    end else if (!quiet) begin
      age_q  <= age_q + 2'h1;
    end
  end

  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_pready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_access_answer: assert property (psel && penable && !pready && paddr != 8'h0c |=> pready)
    else $error("access not answered on the next cycle");
  a_err_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
    else $error("pslverr does not match the address map");
  a_unmapped_zero: assert property (pready && !pwrite && paddr > 8'h14 |-> prdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_reset_idle: assert property ($fell(reset) |-> spi_cs && !spi_sclk && !pready)
    else $error("outputs not idle after reset");
  a_sclk_idle: assert property (!act && !$past(act) && quiet |-> spi_sclk == cpol_q)
    else $error("serial clock not at idle level while deselected");
  a_cs_lead: assert property ($rose(act) && quiet |-> spi_sclk == cpol_q)
    else $error("select asserted with clock off idle");
  a_cs_tail: assert property ($fell(act) && quiet |->
    spi_sclk == cpol_q && $past(spi_sclk) == cpol_q)
    else $error("select released before clock returned to idle");
  a_mosi_setup: assert property (act && quiet && $changed(spi_sclk) &&
    ((spi_sclk != cpol_q) != cpha_q) |-> $stable(spi_mosi))
    else $error("data out changed on a sampling edge");
endmodule

bind csm_spi_master csm_spi_master_chk csm_spi_master_chk_i (
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
  .spi_cs(spi_cs));

// ---- tb/csm_spi_slave_model.sv ----
/*
  Behavioural serial slave: captures words from the master and replies
  with a fixed word sequence. Assumes the bench mirrors the mode settings.
*/
module csm_spi_slave_model (
  input wire logic       spi_sclk,
  input wire logic       spi_mosi,
  input wire logic       spi_cs,
  input wire logic       cpol,
  input wire logic       cpha,
  input wire logic       lsb,
  input wire logic       selh,
  input wire logic [5:0] width,
  output logic           spi_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got [8];
  logic [31:0] sh;
  int          n_got, ib, ob, iw;
  wire         act = (spi_cs == selh);

  function automatic int pos(input int k);
    return lsb ? k : int'(width) - 1 - k;
  endfunction

  task automatic drive();
    logic [31:0] w;
    w = 32'hc3a50f96 ^ (32'h11111111 * iw);
    spi_miso = w[pos(ob)];
    ob++;
    if (ob == int'(width)) begin
      ob = 0;
      iw++;
    end
  endtask

  initial spi_miso = 1'b0;

  always @(act) begin
    if (act) begin
      n_got = 0;
      ib = 0;
      ob = 0;
      iw = 0;
      sh = 32'h0;
      if (!cpha) drive();
    end else
      // No pull on the line: a released line must not look like held data
      spi_miso = ~spi_miso;
  end

  always @(spi_sclk) begin
    if (act && ((spi_sclk != cpol) != cpha)) begin
      sh[pos(ib)] = spi_mosi;
      ib++;
      if (ib == int'(width)) begin
        if (n_got < 8) got[n_got] = sh;
        n_got++;
        ib = 0;
        sh = 32'h0;
      end
    end else if (act)
      drive();
  end
endmodule

// ---- tb/tb_top.sv ----
/*
  Bench for the serial master: APB tasks, a slave model on the link and
  scenarios over clock modes, widths, bit orders and operations.
  Assumes the design, the checker and the slave model are compiled first.
*/
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top
  import csm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic        spi_sclk, spi_mosi, spi_miso, spi_cs, cpol, cpha, lsb, selh;
  logic        clk_en, sk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  width;
  int          errors, n_compared;

  csm_spi_master csm_spi_master_i (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_cs(spi_cs));
  csm_spi_slave_model csm_spi_slave_model_i (
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_cs(spi_cs), .cpol(cpol), .cpha(cpha),
    .lsb(lsb), .selh(selh), .width(width), .spi_miso(spi_miso));

  always #10 sys_clk = ~sys_clk;

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] msk(input logic [5:0] w);
    return 32'((64'h1 << w) - 64'h1);
  endfunction

  function automatic logic [31:0] tw(input int i);
    return (32'h9b6ed215 + 32'h2468ace1 * i) & msk(width);
  endfunction

  task automatic poll(input int b, input logic v);
    int k;
    for (k = 0; k < 3000; k++) begin
      apb(1'b0, 8'h14, 32'h0);
      if (rd[b] === v) break;
    end
    if (k == 3000) begin
      errors++;
      final_report();
    end
  endtask

  task automatic cfg(input logic [1:0] m, input logic l, input logic s, input logic [5:0] w);
    apb(1'b1, 8'h00, {18'h0, w, 4'h0, s, l, m});
    {cpol, cpha} = m;
    lsb = l;
    selh = s;
    width = w;
    repeat (2) @(posedge sys_clk);
    `CHK(spi_cs, ~s)
    `CHK(spi_sclk, m[1])
  endtask

  // More than four pushes: the rest go in after the start, stalling on a full buffer
  task automatic run(input csm_op_e op, input int n, input int push, input int exp_n);
    for (int i = 0; i < push && i < 4; i++) apb(1'b1, 8'h0c, tw(i));
    if (push > 3) begin
      apb(1'b0, 8'h14, 32'h0);
      `CHK(rd[2], 1'b1)
    end
    apb(1'b1, 8'h08, {8'h0, 16'(n), 6'h0, op});
    for (int i = 4; i < push; i++) apb(1'b1, 8'h0c, tw(i));
    for (int i = 0; i < exp_n && op != CSM_OP_WRITE; i++) begin
      poll(1, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      `CHK(rd, (32'hc3a50f96 ^ (32'h11111111 * i)) & msk(width))
    end
    poll(0, 1'b0);
    `CHK(rd[31:16], 16'(exp_n))
    `CHK(rd[3], 1'b1)
    `CHK(csm_spi_slave_model_i.n_got, exp_n)
    for (int i = 0; i < exp_n; i++)
      `CHK(csm_spi_slave_model_i.got[i], (op == CSM_OP_READ) ? 32'h0 : tw(i))
  endtask

  task automatic final_report();
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #1500000;
    errors++;
    final_report();
  end

  initial begin
    logic [5:0] wtab [4];
    wtab = '{6'h08, 6'h05, 6'h10, 6'h20};
    {sys_clk, reset, psel, penable, pwrite} = 5'b01000;
    clk_en = 1'b1;
    {cpol, cpha, lsb, selh} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    width = 6'h08;
    errors = 0;
    n_compared = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h00000800)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h0007a120)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd[4], 1'b1)
    apb(1'b1, 8'h14, 32'h10);
    // Slow enough for the input synchroniser lag to leave data exact
    apb(1'b1, 8'h04, 32'h002625a0);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd[4], 1'b0)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h002625a0)
    for (int m = 0; m < 4; m++) begin
      cfg(2'(m), (m == 1 || m == 2), m[1], wtab[m]);
      run(CSM_OP_XCHG, 2, 2, 2);
    end
    cfg(2'h0, 1'b0, 1'b0, 6'h08);
    run(CSM_OP_READ, 2, 0, 2);
    // Freeze mid-word: a low enable must hold the link exactly where it stands
    apb(1'b1, 8'h08, {8'h0, 16'h0001, 6'h0, CSM_OP_READ});
    repeat (40) @(posedge sys_clk);
    clk_en <= 1'b0;
    @(posedge sys_clk);
    sk = spi_sclk;
    repeat (30) @(posedge sys_clk);
    `CHK(spi_sclk, sk)
    `CHK(spi_cs, 1'b0)
    clk_en <= 1'b1;
    poll(1, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'hc3a50f96 & msk(width))
    poll(0, 1'b0);
    `CHK(rd[31:16], 16'h0001)
    run(CSM_OP_WRITE, 6, 5, 5);
    final_report();
  end
endmodule
